/* hw/mpc_pkg.sv */
// Shared constants
package mpc_pkg;

  // Pin bank layout, one bit per dual-purpose pin
  localparam int NUM_PINS = 11;
  localparam int IDX_DIAG_CLK = 0;
  localparam int IDX_PROBE_A = 1;
  localparam int IDX_PROBE_B = 2;
  localparam int IDX_SER_IN = 3;
  localparam int IDX_SER_OUT = 4;
  localparam int IDX_QUAD_LO = 5;
  localparam int IDX_GLOB_LO = 9;
  localparam int NUM_QUAD = 4;
  localparam int NUM_GLOB = 2;

  // Probe node selection
  localparam int NUM_NODES = 16;
  localparam int SEL_W = 4;

  // Register byte offsets on the bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROBE_SEL = 8'h04;
  localparam logic [7:0] REG_PIN_CFG = 8'h08;
  localparam logic [7:0] REG_UNUSED = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [1:0] MEM_PAGE = 2'h1;

  // Field positions
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_CHK_BIT = 1;
  localparam int SEL_B_LSB = 8;
  localparam int CFG_GLOB_LSB = 4;
  localparam int ST_LP_LSB = 1;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_CHK_BIT = 4;
  localparam int ST_SUM_LSB = 8;
  localparam int ST_RX_LSB = 16;

  // Reset values
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [NUM_QUAD-1:0] QUAD_RST = 4'h0;
  localparam logic [NUM_GLOB-1:0] GLOB_RST = 2'h0;
  localparam logic [NUM_PINS-1:0] UNUSED_RST = 11'h000;

  // Serial command byte: opcode in the top two bits
  localparam logic [1:0] OP_SEL_A = 2'h0;
  localparam logic [1:0] OP_SEL_B = 2'h1;
  localparam logic [1:0] OP_CHECKSUM = 2'h2;
  localparam logic [1:0] OP_LOCK = 2'h3;
  localparam logic [5:0] LOCK_KEY = 6'h2A;

  // Size of the summed table
  localparam int CFG_WORDS = 16;

  // Low-power timing and cycle counts
  localparam int CLK_MHZ = 40;
  localparam int LP_ENTRY_NS = 800;
  localparam int LP_EXIT_US = 200;
  localparam int LP_ENTRY_CYC = (LP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int LP_EXIT_CYC = LP_EXIT_US * CLK_MHZ;
  localparam int LP_CNT_W = 14;

  // Low-power sequencer states
  typedef enum logic [1:0] {
    LPS_RUN = 2'b00,
    LPS_ENTER = 2'b01,
    LPS_SLEEP = 2'b10,
    LPS_EXIT = 2'b11
  } mpc_lp_e;

endpackage : mpc_pkg

/* hw/mpc_pin_ctl.sv */
`timescale 1ns/1ps
// What this block does
// - Mode high: diagnostic clock pin drives link
// - Probe pins probe only while mode high
// - Probe pins show selected internal node live
// - One-way permanent probe disable
// - Serial input takes link data in mode
// - Serial output drives link data in mode
// - Serial output driven during checksum command
// - Enter low power 800 ns after rise
// - Low power: tristate, inputs off, core off
// - Resume normal operation within 200 us
// - Mode pin governs diagnostic, probe and serial pins
// - Quadrant clock unused becomes user I/O
// - Global clock buffered, else user I/O
// - Unused pins pulled low or tristated
module mpc_pin_ctl
  import mpc_pkg::*;
#(
  parameter int EXIT_CYC = LP_EXIT_CYC,
  parameter bit LARGE_MEMBER = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pins
  input wire logic mode_pin_i,
  input wire logic low_power_pin_i,
  // Diagnostic clock pin, also the link clock
  input wire logic diagnostic_clock_input_i,
  output logic diagnostic_clock_input_o,
  output logic diagnostic_clock_input_oe,
  // Probe pins
  input wire logic probe_out_a_i,
  output logic probe_out_a_o,
  output logic probe_out_a_oe,
  input wire logic probe_out_b_i,
  output logic probe_out_b_o,
  output logic probe_out_b_oe,
  // Serial pins
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  // Quadrant and global clock pins
  input wire logic [NUM_QUAD-1:0] quadrant_clock_i,
  output logic [NUM_QUAD-1:0] quadrant_clock_o,
  output logic [NUM_QUAD-1:0] quadrant_clock_oe,
  input wire logic [NUM_GLOB-1:0] global_clock_i,
  output logic [NUM_GLOB-1:0] global_clock_o,
  output logic [NUM_GLOB-1:0] global_clock_oe,
  // User core side
  input wire logic [NUM_PINS-1:0] user_out_i,
  input wire logic [NUM_PINS-1:0] user_oe_i,
  output logic [NUM_PINS-1:0] user_in_o,
  input wire logic [NUM_NODES-1:0] probe_node_i,
  output logic [NUM_QUAD-1:0] quad_ctl_o,
  output logic [NUM_GLOB-1:0] glob_clk_o,
  output logic core_enable_o
);

  // Synchronisers for mode and low-power pins
  logic mode_s1_q;
  logic mode_s2_q;
  logic lp_s1_q;
  logic lp_s2_q;
  // Pin input synchronisers
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1_q;
  logic [NUM_PINS-1:0] pin_s2_q;

  // Low-power sequencer
  mpc_lp_e lp_state_q;
  mpc_lp_e lp_state_d;
  logic [LP_CNT_W-1:0] lp_cnt_q;
  logic [LP_CNT_W-1:0] lp_cnt_d;
  logic lp_off;

  // Software registers
  logic lock_q;
  logic [SEL_W-1:0] sel_a_q;
  logic [SEL_W-1:0] sel_b_q;
  logic [NUM_QUAD-1:0] quad_used_q;
  logic [NUM_GLOB-1:0] glob_used_q;
  logic [NUM_PINS-1:0] unused_q;
  logic [7:0] cfg_mem_q [CFG_WORDS];
  logic ack_q;
  logic [31:0] rdata_q;

  // Probe output flops
  logic probe_a_q;
  logic probe_b_q;

  // Checksum engine
  logic chk_busy_q;
  logic chk_ready_q;
  logic [3:0] chk_idx_q;
  logic [7:0] chk_sum_q;
  logic chk_active;

  // Serial byte crossing into clk domain
  logic rx_t_s1_q;
  logic rx_t_s2_q;
  logic rx_t_d_q;
  logic rx_new;
  // Shift-out done crossing into clk domain
  logic dn_t_s1_q;
  logic dn_t_s2_q;
  logic dn_t_d_q;
  logic tx_done;

  // Link-domain state, all on the diagnostic clock
  logic l_rst_s1_q;
  logic l_rst_s2_q;
  logic l_mode_s1_q;
  logic l_mode_s2_q;
  logic l_rdy_s1_q;
  logic l_rdy_s2_q;
  logic l_rdy_d_q;
  logic [6:0] rx_sh_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic sout_q;
  logic done_tgl_q;

  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_cfg;
  logic wr_unused;
  logic wr_mem;
  logic [3:0] mem_idx;
  logic [31:0] rdata_d;

  // Serial command decode
  logic [1:0] cmd_op;
  logic [5:0] cmd_arg;
  logic cmd_sel_a;
  logic cmd_sel_b;
  logic cmd_chk;
  logic cmd_lock;
  logic chk_start;

  // Pin function selection
  logic [NUM_PINS-1:0] func_en;
  logic [NUM_PINS-1:0] func_o;
  logic [NUM_PINS-1:0] func_oe;
  logic [NUM_PINS-1:0] pin_o;
  logic [NUM_PINS-1:0] pin_oe;
  logic probe_mode;

  // Gather pin inputs into one bank
  assign pin_raw = {global_clock_i, quadrant_clock_i, serial_out_pin_i,
                    serial_in_pin_i, probe_out_b_i, probe_out_a_i,
                    diagnostic_clock_input_i};

  // input synchronisers
  // Two flops on each pin input; glob_clk_o and the link shifters bypass them
  always_ff @(posedge clk_i)
  begin
    mode_s1_q <= mode_pin_i;
    mode_s2_q <= mode_s1_q;
    lp_s1_q <= low_power_pin_i;
    lp_s2_q <= lp_s1_q;
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end

  // entry delay timing
  // Next state and counter for the low-power sequencer
  always_comb
  begin
    lp_state_d = lp_state_q;
    lp_cnt_d = lp_cnt_q + 14'h0001;
    unique case (lp_state_q)
      // Normal operation, wait for the pin to rise
      LPS_RUN:
      begin
        lp_cnt_d = 14'h0000;
        if (lp_s2_q)
          lp_state_d = LPS_ENTER;
      end
      // Count entry latency, abort on fall
      LPS_ENTER:
      begin
        if (!lp_s2_q)
        begin
          lp_state_d = LPS_RUN;
        end
        else if (lp_cnt_q == LP_CNT_W'(LP_ENTRY_CYC - 1))
        begin
          lp_state_d = LPS_SLEEP;
        end
      end
      // Stay asleep until the pin goes low
      LPS_SLEEP:
      begin
        lp_cnt_d = 14'h0000;
        if (!lp_s2_q)
          lp_state_d = LPS_EXIT;
      end
      LPS_EXIT:
      begin
        if (lp_s2_q)
        begin
          lp_state_d = LPS_SLEEP;
        end
        else if (lp_cnt_q == LP_CNT_W'(EXIT_CYC - 1))
        begin
          lp_state_d = LPS_RUN;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lp_state_q <= LPS_RUN;
      lp_cnt_q <= 14'h0000;
    end
    else
    begin
      lp_state_q <= lp_state_d;
      lp_cnt_q <= lp_cnt_d;
    end
  end

  // core off while asleep or waking
  assign lp_off = (lp_state_q == LPS_SLEEP) || (lp_state_q == LPS_EXIT);
  assign core_enable_o = !lp_off;

  // Bus address decode
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_ctrl = wb_wr && (wb_adr_i == REG_CTRL);
  assign wr_sel = wb_req && wb_we_i && (wb_adr_i == REG_PROBE_SEL);
  assign wr_cfg = wb_wr && (wb_adr_i == REG_PIN_CFG);
  assign wr_unused = wb_req && wb_we_i && (wb_adr_i == REG_UNUSED);
  assign wr_mem = wb_wr && (wb_adr_i[7:6] == MEM_PAGE);
  assign mem_idx = wb_adr_i[5:2];

  // Serial command decode from the crossed byte
  assign cmd_op = rx_byte_q[7:6];
  assign cmd_arg = rx_byte_q[5:0];
  assign cmd_sel_a = rx_new && (cmd_op == OP_SEL_A);
  assign cmd_sel_b = rx_new && (cmd_op == OP_SEL_B);
  assign cmd_chk = rx_new && (cmd_op == OP_CHECKSUM);
  assign cmd_lock = rx_new && (cmd_op == OP_LOCK) && (cmd_arg == LOCK_KEY);
  assign chk_start = !chk_active && (cmd_chk ||
                     (wr_ctrl && wb_dat_i[CTRL_CHK_BIT]));

  // Read data selection, unmapped offsets read zero
  assign rdata_d =
    (wb_adr_i == REG_CTRL) ? {31'h0, lock_q} :
    (wb_adr_i == REG_PROBE_SEL) ?
      {20'h0, sel_b_q, 4'h0, sel_a_q} :
    (wb_adr_i == REG_PIN_CFG) ? {26'h0, glob_used_q, quad_used_q} :
    (wb_adr_i == REG_UNUSED) ? {21'h0, unused_q} :
    (wb_adr_i == REG_STATUS) ?
      {8'h0, rx_byte_q, chk_sum_q, 3'h0, chk_active, lock_q,
       lp_state_q, mode_s2_q} :
    (wb_adr_i[7:6] == MEM_PAGE) ? {24'h0, cfg_mem_q[mem_idx]} :
    32'h0000_0000;

  // Bus answer: one wait state, ack dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      rdata_q <= rdata_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // sticky probe disable
  // Set by bus or link; reset never clears it
  always_ff @(posedge clk_i)
  begin
    if (cmd_lock || (wr_ctrl && wb_dat_i[CTRL_LOCK_BIT]))
      lock_q <= 1'b1;
    else if (rst_i && (lock_q !== 1'b1))
      lock_q <= 1'b0;
  end

  // Probe selects, bus wins over link
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_a_q <= SEL_RST;
      sel_b_q <= SEL_RST;
    end
    else if (wr_sel)
    begin
      if (wb_sel_i[0])
        sel_a_q <= wb_dat_i[SEL_W-1:0];
      if (wb_sel_i[1])
        sel_b_q <= wb_dat_i[SEL_B_LSB +: SEL_W];
    end
    else
    begin
      if (cmd_sel_a)
        sel_a_q <= cmd_arg[SEL_W-1:0];
      if (cmd_sel_b)
        sel_b_q <= cmd_arg[SEL_W-1:0];
    end
  end

  // Pin usage configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      quad_used_q <= QUAD_RST;
      glob_used_q <= GLOB_RST;
      unused_q <= UNUSED_RST;
    end
    else
    begin
      if (wr_cfg)
        {glob_used_q, quad_used_q} <= wb_dat_i[5:0];
      if (wr_unused && wb_sel_i[0])
        unused_q[7:0] <= wb_dat_i[7:0];
      if (wr_unused && wb_sel_i[1])
        unused_q[10:8] <= wb_dat_i[10:8];
    end
  end

  // Configuration table covered by the checksum
  always_ff @(posedge clk_i)
  begin
    if (wr_mem)
      cfg_mem_q[mem_idx] <= wb_dat_i[7:0];
  end

  // live probe of selected nodes
  // Chosen node, one clock of lag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      probe_a_q <= 1'b0;
      probe_b_q <= 1'b0;
    end
    else
    begin
      probe_a_q <= probe_node_i[sel_a_q];
      probe_b_q <= probe_node_i[sel_b_q];
    end
  end

  // checksum holds serial output
  // Sum the table, hold until shifted out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chk_busy_q <= 1'b0;
      chk_ready_q <= 1'b0;
      chk_idx_q <= 4'h0;
      chk_sum_q <= 8'h00;
    end
    else if (chk_start)
    begin
      chk_busy_q <= 1'b1;
      chk_idx_q <= 4'h0;
      chk_sum_q <= 8'h00;
    end
    else if (chk_busy_q)
    begin
      chk_sum_q <= chk_sum_q + cfg_mem_q[chk_idx_q];
      chk_idx_q <= chk_idx_q + 4'h1;
      if (chk_idx_q == 4'hF)
      begin
        chk_busy_q <= 1'b0;
        chk_ready_q <= 1'b1;
      end
    end
    else if (tx_done)
    begin
      chk_ready_q <= 1'b0;
    end
  end
  assign chk_active = chk_busy_q || chk_ready_q;

  // Toggle crossings from the link domain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {rx_t_s1_q, rx_t_s2_q, rx_t_d_q} <= 3'h0;
      {dn_t_s1_q, dn_t_s2_q, dn_t_d_q} <= 3'h0;
    end
    else
    begin
      {rx_t_s1_q, rx_t_s2_q, rx_t_d_q} <= {rx_tgl_q, rx_t_s1_q, rx_t_s2_q};
      {dn_t_s1_q, dn_t_s2_q, dn_t_d_q} <= {done_tgl_q, dn_t_s1_q, dn_t_s2_q};
    end
  end
  assign rx_new = rx_t_s2_q ^ rx_t_d_q;
  assign tx_done = dn_t_s2_q ^ dn_t_d_q;

  // Link-domain synchronisers
  always_ff @(posedge diagnostic_clock_input_i)
  begin
    l_rst_s1_q <= rst_i;
    l_rst_s2_q <= l_rst_s1_q;
    l_mode_s1_q <= mode_pin_i;
    l_mode_s2_q <= l_mode_s1_q;
    l_rdy_s1_q <= chk_ready_q;
    l_rdy_s2_q <= l_rdy_s1_q;
    l_rdy_d_q <= l_rdy_s2_q;
  end

  // serial input shifted in mode
  // Receive shifter, first bit is the MSB
  always_ff @(posedge diagnostic_clock_input_i)
  begin
    if (l_rst_s2_q || !l_mode_s2_q)
    begin
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 7'h00;
    end
    else
    begin
      rx_sh_q <= {rx_sh_q[5:0], serial_in_pin_i};
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  // Byte held stable while its toggle crosses
  always_ff @(posedge diagnostic_clock_input_i)
  begin
    if (l_rst_s2_q)
    begin
      rx_byte_q <= 8'h00;
      rx_tgl_q <= 1'b0;
    end
    else if (l_mode_s2_q && (rx_cnt_q == 3'h7))
    begin
      rx_byte_q <= {rx_sh_q, serial_in_pin_i};
      rx_tgl_q <= !rx_tgl_q;
    end
  end

  // serial output shifter
  // Load sum on ready, shift eight bits
  always_ff @(posedge diagnostic_clock_input_i)
  begin
    if (l_rst_s2_q)
    begin
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 4'h0;
      sout_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end
    else if (l_rdy_s2_q && !l_rdy_d_q)
    begin
      tx_sh_q <= chk_sum_q;
      tx_cnt_q <= 4'h8;
    end
    else if (tx_cnt_q != 4'h0)
    begin
      sout_q <= tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      tx_cnt_q <= tx_cnt_q - 4'h1;
      if (tx_cnt_q == 4'h1)
        done_tgl_q <= !done_tgl_q;
    end
  end

  // probe pins need mode and no lock
  assign probe_mode = mode_s2_q && !lock_q;

  assign func_en = {glob_used_q, quad_used_q, mode_s2_q || chk_active,
                    mode_s2_q, probe_mode, probe_mode, mode_s2_q};
  assign func_oe = {6'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  assign func_o = {6'h00, sout_q, 1'b0, probe_b_q, probe_a_q, 1'b0};

  // every pin tristated in low power
  assign pin_oe = lp_off ? '0 :
                  (func_en & func_oe) |
                  (~func_en & unused_q & {NUM_PINS{!LARGE_MEMBER}}) |
                  (~func_en & ~unused_q & user_oe_i);
  assign pin_o = (func_en & func_o) | (~func_en & ~unused_q & user_out_i);

  // Input buffers off in low power or special use
  assign user_in_o = lp_off ? '0 : (pin_s2_q & ~func_en);
  assign quad_ctl_o = lp_off ? '0 :
                      (pin_s2_q[IDX_QUAD_LO +: NUM_QUAD] & quad_used_q);
  // Clock buffer path, no synchroniser on a clock
  assign glob_clk_o = lp_off ? '0 : (global_clock_i & glob_used_q);

  // Spread the bank back onto the pins
  assign diagnostic_clock_input_o = pin_o[IDX_DIAG_CLK];
  assign diagnostic_clock_input_oe = pin_oe[IDX_DIAG_CLK];
  assign probe_out_a_o = pin_o[IDX_PROBE_A];
  assign probe_out_a_oe = pin_oe[IDX_PROBE_A];
  assign probe_out_b_o = pin_o[IDX_PROBE_B];
  assign probe_out_b_oe = pin_oe[IDX_PROBE_B];
  assign serial_in_pin_o = pin_o[IDX_SER_IN];
  assign serial_in_pin_oe = pin_oe[IDX_SER_IN];
  assign serial_out_pin_o = pin_o[IDX_SER_OUT];
  assign serial_out_pin_oe = pin_oe[IDX_SER_OUT];
  assign quadrant_clock_o = pin_o[IDX_QUAD_LO +: NUM_QUAD];
  assign quadrant_clock_oe = pin_oe[IDX_QUAD_LO +: NUM_QUAD];
  assign global_clock_o = pin_o[IDX_GLOB_LO +: NUM_GLOB];
  assign global_clock_oe = pin_oe[IDX_GLOB_LO +: NUM_GLOB];

endmodule : mpc_pin_ctl

/* test/mpc_monitor.sv */
`timescale 1ns/1ps
// Port checks
module mpc_monitor
  import mpc_pkg::*;
#(
  parameter int EXIT_CYC = LP_EXIT_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins and core side
  input wire logic mode_pin_i,
  input wire logic low_power_pin_i,
  input wire logic core_enable_o,
  input wire logic diagnostic_clock_input_oe,
  input wire logic serial_out_pin_oe,
  input wire logic probe_out_a_oe,
  input wire logic [NUM_QUAD-1:0] quadrant_clock_oe,
  input wire logic [NUM_QUAD-1:0] quad_ctl_o,
  input wire logic [NUM_GLOB-1:0] global_clock_i,
  input wire logic [NUM_GLOB-1:0] glob_clk_o,
  input wire logic [NUM_PINS-1:0] user_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Run lengths of the low-power pin, saturating
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  // Count cycles high and low
  always_ff @(posedge clk_i)
  begin
    hi_q <= !low_power_pin_i ? 16'h0 : hi_q + 16'(!hi_q[15]);
    lo_q <= low_power_pin_i ? 16'h0 : lo_q + 16'(!lo_q[15]);
  end
  // Mode held past the synchroniser
  sequence mode_held;
    mode_pin_i [*5];
  endsequence
  // A request not yet answered
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_follows_req_a:
    assert property (bus_req |=> wb_ack_o) else $error("no bus answer");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_needs_req_a:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("stray ack");
  entry_not_early_a:
    assert property (hi_q != 16'h0 && hi_q <= 16'h0020 |-> core_enable_o)
      else $error("early sleep");
  entry_reached_a:
    assert property (hi_q == 16'h0028 |-> !core_enable_o)
      else $error("no sleep");
  sleep_isolated_a:
    assert property (!core_enable_o |-> !diagnostic_clock_input_oe &&
      !serial_out_pin_oe && !probe_out_a_oe && quadrant_clock_oe == '0 &&
      user_in_o == '0 && quad_ctl_o == '0 && glob_clk_o == '0)
      else $error("pins live asleep");
  exit_not_early_a:
    assert property ($rose(core_enable_o) |-> lo_q >= 16'(EXIT_CYC))
      else $error("early wake");
  exit_reached_a:
    assert property (lo_q == 16'(EXIT_CYC + 8) |-> core_enable_o)
      else $error("no wake");
  diag_function_a:
    assert property (mode_held |-> !diagnostic_clock_input_oe &&
      !user_in_o[IDX_DIAG_CLK] && !user_in_o[IDX_SER_IN])
      else $error("diag pins in user role");
  serial_drive_a:
    assert property (mode_held ##0 core_enable_o |-> serial_out_pin_oe)
      else $error("serial out idle");
  quad_role_a:
    assert property ((quad_ctl_o & quadrant_clock_oe) == '0)
      else $error("control pin driven");
  glob_buffer_a:
    assert property ((glob_clk_o & ~global_clock_i) == '0)
      else $error("bad clock buffer");
endmodule : mpc_monitor

bind mpc_pin_ctl mpc_monitor #(.EXIT_CYC(EXIT_CYC)) u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mode_pin_i,
  .low_power_pin_i, .core_enable_o, .diagnostic_clock_input_oe,
  .serial_out_pin_oe, .probe_out_a_oe, .quadrant_clock_oe, .quad_ctl_o,
  .global_clock_i, .glob_clk_o, .user_in_o
);

/* test/mpc_link_model.sv */
`timescale 1ns/1ps
// Diagnostic equipment on the link
module mpc_link_model (
  // Driven lines
  output logic lclk_o,
  output logic sdat_o,
  // Serial output wire level
  input wire logic sout_i
);
  // Serial output history, newest in bit 0
  logic [63:0] cap;
  // Link clock stands still outside frames
  initial
  begin
    lclk_o = 1'h0;
    sdat_o = 1'h0;
    cap = '0;
  end
  // One 15 ns link period, output sampled after the fall
  task automatic tick();
    #7.5 lclk_o = 1'h1;
    #7.5 lclk_o = 1'h0;
    cap = {cap[62:0], sout_i};
  endtask : tick
  // Plain clock burst
  task automatic run(input int n);
    #3;
    repeat (n) tick();
  endtask : run
  task automatic send(input logic [7:0] b);
    #3;
    for (int i = 7; i >= 0; i--)
    begin
      sdat_o = b[i];
      tick();
    end
    // Released line shows the inverse level
    sdat_o = ~b[0];
  endtask : send
endmodule : mpc_link_model

/* test/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench
module testbench
  import mpc_pkg::*;
;
  localparam int EXIT_N = 20;
  // Clock, reset and bus
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  // Pins and core side
  logic mode_pin_i, low_power_pin_i, core_enable_o;
  logic diagnostic_clock_input_i, diagnostic_clock_input_o;
  logic diagnostic_clock_input_oe, serial_in_pin_i, serial_in_pin_o;
  logic serial_in_pin_oe, serial_out_pin_i, serial_out_pin_o;
  logic serial_out_pin_oe, probe_out_a_i, probe_out_a_o, probe_out_a_oe;
  logic probe_out_b_i, probe_out_b_o, probe_out_b_oe;
  logic [NUM_QUAD-1:0] quadrant_clock_i, quadrant_clock_o;
  logic [NUM_QUAD-1:0] quadrant_clock_oe, quad_ctl_o;
  logic [NUM_GLOB-1:0] global_clock_i, global_clock_o;
  logic [NUM_GLOB-1:0] global_clock_oe, glob_clk_o;
  logic [NUM_PINS-1:0] user_out_i, user_oe_i, user_in_o, pin_x;
  logic [NUM_NODES-1:0] probe_node_i;
  int n_fail = 0, n_checks = 0;
  // Wire levels of shared pins
  assign serial_out_pin_i = serial_out_pin_oe ? serial_out_pin_o : pin_x[4];
  assign probe_out_a_i = probe_out_a_oe ? probe_out_a_o : pin_x[1];
  assign probe_out_b_i = probe_out_b_oe ? probe_out_b_o : pin_x[2];
  mpc_pin_ctl #(.EXIT_CYC(EXIT_N), .LARGE_MEMBER(1'h1)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_pin_i, .low_power_pin_i,
    .diagnostic_clock_input_i, .diagnostic_clock_input_o,
    .diagnostic_clock_input_oe, .probe_out_a_i, .probe_out_a_o,
    .probe_out_a_oe, .probe_out_b_i, .probe_out_b_o, .probe_out_b_oe,
    .serial_in_pin_i, .serial_in_pin_o, .serial_in_pin_oe,
    .serial_out_pin_i, .serial_out_pin_o, .serial_out_pin_oe,
    .quadrant_clock_i, .quadrant_clock_o, .quadrant_clock_oe,
    .global_clock_i, .global_clock_o, .global_clock_oe, .user_out_i,
    .user_oe_i, .user_in_o, .probe_node_i, .quad_ctl_o, .glob_clk_o,
    .core_enable_o
  );
  // Far-side equipment
  mpc_link_model lm (
    .lclk_o(diagnostic_clock_input_i),
    .sdat_o(serial_in_pin_i),
    .sout_i(serial_out_pin_i)
  );
  // 40 MHz clock
  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial
  begin
    #2000000;
    n_fail++;
    test_done();
  end
  // Wait whole cycles
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic bus cycle, read data left in rd
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, 4'hF};
    // Ack and data are sampled at the rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 16);
    if (n >= 16)
    begin
      n_fail++;
      test_done();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  // Reset values, masking, unmapped
  task automatic t_regs();
    wb(1'h0, REG_PIN_CFG, 32'h0);
    chk("pin cfg", 32'h0, rd);
    wb(1'h0, REG_STATUS, 32'h0);
    chk("status", 32'h0, rd & 32'h0000001F);
    wb(1'h1, REG_PROBE_SEL, 32'hFFFFFFFF);
    wb(1'h0, REG_PROBE_SEL, 32'h0);
    chk("probe sel", 32'h00000F0F, rd);
    wb(1'h1, 8'h20, 32'hFFFFFFFF);
    wb(1'h0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs
  // Mode low: every pin in the user role
  task automatic t_user();
    user_oe_i <= '1;
    user_out_i <= 11'h015;
    w(4);
    chk("pin oe", 32'h1F, 32'({serial_out_pin_oe, serial_in_pin_oe,
      probe_out_b_oe, probe_out_a_oe, diagnostic_clock_input_oe}));
    chk("pin out", 32'h15, 32'({serial_out_pin_o, serial_in_pin_o,
      probe_out_b_o, probe_out_a_o, diagnostic_clock_input_o}));
    user_oe_i <= '0;
    pin_x <= 11'h002;
    w(5);
    chk("user in", 32'h002, 32'(user_in_o));
  endtask : t_user
  // Mode high: live probes, serial selection
  task automatic t_mode();
    wb(1'h1, REG_PROBE_SEL, 32'h00000C03);
    probe_node_i <= 16'h1008;
    mode_pin_i <= 1'h1;
    w(6);
    chk("probe oe", 32'h3, 32'({probe_out_a_oe, probe_out_b_oe}));
    chk("probe val", 32'h3, 32'({probe_out_a_o, probe_out_b_o}));
    probe_node_i <= 16'h0088;
    w(3);
    chk("probe live", 32'h2, 32'({probe_out_a_o, probe_out_b_o}));
    // Let the mode level pass the link synchroniser
    lm.run(2);
    lm.send(8'h05);
    w(8);
    chk("serial sel", 32'h0, 32'(probe_out_a_o));
    wb(1'h0, REG_STATUS, 32'h0);
    chk("serial byte", 32'h05, 32'(rd[23:16]));
    mode_pin_i <= 1'h0;
    w(6);
    chk("probe user", 32'h0, 32'(probe_out_a_oe));
  endtask : t_mode
  // Clock pins in both roles, unused pins
  task automatic t_pins();
    user_oe_i <= '1;
    quadrant_clock_i <= 4'hF;
    global_clock_i <= 2'h3;
    wb(1'h1, REG_PIN_CFG, 32'h00000015);
    w(4);
    chk("clock pins", 32'h5A6, 32'({quad_ctl_o, quadrant_clock_oe,
      glob_clk_o, global_clock_oe}));
    wb(1'h1, REG_PIN_CFG, 32'h0);
    wb(1'h1, REG_UNUSED, 32'h00000400);
    wb(1'h0, REG_UNUSED, 32'h0);
    chk("unused reg", 32'h400, rd);
    chk("unused oe", 32'h1, 32'(global_clock_oe));
    wb(1'h1, REG_UNUSED, 32'h0);
  endtask : t_pins
  // Checksum run with mode low
  task automatic t_chk();
    logic [7:0] s = 8'h0;
    logic hit = 1'h0;
    user_oe_i <= '0;
    for (int i = 0; i < CFG_WORDS; i++)
    begin
      wb(1'h1, 8'(8'h40 + 4 * i), 32'(8'(i * 17 + 3)));
      s = s + 8'(i * 17 + 3);
    end
    wb(1'h1, REG_CTRL, 32'h2);
    w(2);
    chk("chk drive", 32'h1, 32'(serial_out_pin_oe));
    w(30);
    lm.run(40);
    w(8);
    wb(1'h0, REG_STATUS, 32'h0);
    chk("chk sum", 32'({s, 8'h00}), rd & 32'h0000FF10);
    chk("chk release", 32'h0, 32'(serial_out_pin_oe));
    for (int i = 0; i < 57; i++)
      hit = hit | (lm.cap[i+:8] === s);
    chk("chk stream", 32'h1, 32'(hit));
  endtask : t_chk
  // Aborted entry, full entry and exit
  task automatic t_lp();
    low_power_pin_i <= 1'h1;
    w(10);
    low_power_pin_i <= 1'h0;
    w(40);
    chk("lp abort", 32'h1, 32'(core_enable_o));
    low_power_pin_i <= 1'h1;
    w(31);
    chk("lp early", 32'h1, 32'(core_enable_o));
    w(10);
    chk("lp sleep", 32'h0, 32'({core_enable_o, user_in_o}));
    low_power_pin_i <= 1'h0;
    w(EXIT_N + 8);
    wb(1'h0, REG_STATUS, 32'h0);
    chk("lp resume", 32'h1, 32'({rd[2:1], core_enable_o}));
  endtask : t_lp
  // Permanent probe disable survives reset
  task automatic t_lock();
    wb(1'h1, REG_CTRL, 32'h1);
    mode_pin_i <= 1'h1;
    w(6);
    chk("lock probe", 32'h0, 32'(probe_out_a_oe));
    rst_i <= 1'h1;
    w(4);
    rst_i <= 1'h0;
    w(6);
    wb(1'h0, REG_STATUS, 32'h0);
    chk("lock kept", 32'h3, 32'({rd[3], !probe_out_a_oe}));
    mode_pin_i <= 1'h0;
  endtask : t_lock
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Main sequence
  initial
  begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, mode_pin_i, low_power_pin_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, pin_x, quadrant_clock_i} = '0;
    {global_clock_i, user_out_i, user_oe_i, probe_node_i} = '0;
    lm.run(4);
    w(16);
    rst_i <= 1'h0;
    // Link reset release needs two link edges
    lm.run(2);
    t_regs();
    t_user();
    t_mode();
    t_pins();
    t_chk();
    t_lp();
    t_lock();
    test_done();
  end
endmodule : testbench
